// ---- hdl/slave_state_pkg.sv ----
// Purpose: Shared constants and types for the fieldbus slave state machine.
// Assumes: Single 40 MHz clock domain.
// Notes:   State codes are the values presented in the state field.
package slave_state_pkg;

  localparam logic [3:0] ST_INIT_CODE = 4'h1;
  localparam logic [3:0] ST_PREOP_CODE = 4'h2;
  localparam logic [3:0] ST_BOOT_CODE = 4'h3;
  localparam logic [3:0] ST_SAFEOP_CODE = 4'h4;
  localparam logic [3:0] ST_OP_CODE = 4'h8;

  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_BAD_TRANSITION = 4'h1;
  localparam logic [3:0] ERR_MAILBOX_CFG = 4'h2;
  localparam logic [3:0] ERR_PD_CFG = 4'h3;
  localparam logic [3:0] ERR_UNKNOWN_STATE = 4'h4;

  localparam int DATA_W_DEFAULT = 16;

  typedef enum logic [2:0] {
    ST_INIT   = 3'b000,
    ST_PREOP  = 3'b001,
    ST_BOOT   = 3'b010,
    ST_SAFEOP = 3'b011,
    ST_OP     = 3'b100
  } slave_state_t;

  function automatic logic [3:0] state_code(input slave_state_t s);
    case (s)
      ST_INIT:   state_code = ST_INIT_CODE;
      ST_PREOP:  state_code = ST_PREOP_CODE;
      ST_BOOT:   state_code = ST_BOOT_CODE;
      ST_SAFEOP: state_code = ST_SAFEOP_CODE;
      ST_OP:     state_code = ST_OP_CODE;
      default:   state_code = ST_INIT_CODE;
    endcase
  endfunction

endpackage

// ---- hdl/reset_sync.sv ----
// Purpose: Two-flip-flop release synchroniser for the active-low reset.
// Assumes: rstn_i may be asserted at any time.
// Notes:   Assertion is immediate, release follows two clock edges.
`timescale 1ns/10ps
`default_nettype none
module reset_sync (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  output var  logic rstn_o
);
  logic meta_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= 1'b0;
      rstn_o   <= 1'b0;
    end else begin
      meta_reg <= 1'b1;
      rstn_o   <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/slave_state_machine.sv ----
// Purpose: Communication state machine of a fieldbus slave with service gating.
// Assumes: Master request and configuration checks come from logic on clk_i.
// Notes:   A request is evaluated on a one-cycle req_valid_i pulse.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - State changes only on master requests.
// - Power-on enters Init, code 01h.
// - Init refuses mailbox and process data.
// - Init to Pre-Op checks mailbox configuration.
// - Pre-Op allows mailbox, Ethernet tunnel, no process.
// - Safe-Op updates inputs, outputs held off.
// - Pre-Op to Safe-Op checks process channels.
// - Copy inputs to process memory in the same cycle as the acknowledge.
// - Safe-Op permits mailbox and process data.
// - Op copies outputs, returns inputs each cycle.
// - Op permits process data and mailbox together.
// - Bootstrap from Init only, file transfer only.
module slave_state_machine #(
  parameter int DATA_W = slave_state_pkg::DATA_W_DEFAULT
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              req_valid_i,
  input  wire logic [3:0]        req_state_i,
  input  wire logic              mailbox_cfg_ok_i,
  input  wire logic              pd_cfg_ok_i,
  input  wire logic              cycle_i,
  input  wire logic [DATA_W-1:0] input_data_i,
  input  wire logic [DATA_W-1:0] master_out_data_i,
  output var  logic [3:0]        state_code_o,
  output var  logic              ack_o,
  output var  logic              error_o,
  output var  logic [3:0]        error_code_o,
  output var  logic              mailbox_en_o,
  output var  logic              eoe_en_o,
  output var  logic              file_xfer_en_o,
  output var  logic              pd_en_o,
  output var  logic              mem_wr_o,
  output var  logic [DATA_W-1:0] dual_port_process_memory_o,
  output var  logic [DATA_W-1:0] phys_out_o
);

  // Refuse a data width that the copy paths cannot carry.
  if (DATA_W < 1) begin : gen_bad_width
    $error("DATA_W must be at least 1");
  end

  logic rstn;

  reset_sync u_reset_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .rstn_o (rstn)
  );

  typedef struct packed {
    slave_state_pkg::slave_state_t state;
    logic [3:0]                    code;
    logic                          ack;
    logic                          err;
    logic [3:0]                    err_code;
    logic                          mbx;
    logic                          eoe;
    logic                          foe;
    logic                          pd;
    logic                          mem_wr;
    logic [DATA_W-1:0]             mem;
    logic [DATA_W-1:0]             outs;
  } sm_t;

  sm_t sm_reg;
  sm_t sm_next;

  always_comb begin
    slave_state_pkg::slave_state_t tgt;
    logic                          legal;
    logic                          known;
    logic [3:0]                    fail;
    tgt   = sm_reg.state;
    legal = 1'b0;
    known = 1'b1;
    fail  = slave_state_pkg::ERR_NONE;
    sm_next        = sm_reg;
    sm_next.ack    = 1'b0;
    sm_next.mem_wr = 1'b0;
    case (req_state_i)
      slave_state_pkg::ST_INIT_CODE:   tgt = slave_state_pkg::ST_INIT;
      slave_state_pkg::ST_PREOP_CODE:  tgt = slave_state_pkg::ST_PREOP;
      slave_state_pkg::ST_BOOT_CODE:   tgt = slave_state_pkg::ST_BOOT;
      slave_state_pkg::ST_SAFEOP_CODE: tgt = slave_state_pkg::ST_SAFEOP;
      slave_state_pkg::ST_OP_CODE:     tgt = slave_state_pkg::ST_OP;
      default:                         known = 1'b0;
    endcase
    // Permitted moves: any state back to Init, up one step, Init to Boot, Safe-Op down to Pre-Op, Op down to Safe-Op or Pre-Op.
    unique case (sm_reg.state)
      slave_state_pkg::ST_INIT:   legal = tgt inside {slave_state_pkg::ST_INIT, slave_state_pkg::ST_PREOP,
                                                      slave_state_pkg::ST_BOOT};
      slave_state_pkg::ST_PREOP:  legal = tgt inside {slave_state_pkg::ST_INIT, slave_state_pkg::ST_PREOP,
                                                      slave_state_pkg::ST_SAFEOP};
      slave_state_pkg::ST_BOOT:   legal = tgt inside {slave_state_pkg::ST_INIT, slave_state_pkg::ST_BOOT};
      slave_state_pkg::ST_SAFEOP: legal = tgt != slave_state_pkg::ST_BOOT;
      slave_state_pkg::ST_OP:     legal = tgt != slave_state_pkg::ST_BOOT;
    endcase
    if (!known) begin
      fail = slave_state_pkg::ERR_UNKNOWN_STATE;
    end else if (!legal) begin
      fail = slave_state_pkg::ERR_BAD_TRANSITION;
    end else if (sm_reg.state == slave_state_pkg::ST_INIT && tgt == slave_state_pkg::ST_PREOP
                 && !mailbox_cfg_ok_i) begin
      fail = slave_state_pkg::ERR_MAILBOX_CFG;
    end else if (sm_reg.state == slave_state_pkg::ST_PREOP && tgt == slave_state_pkg::ST_SAFEOP
                 && !pd_cfg_ok_i) begin
      fail = slave_state_pkg::ERR_PD_CFG;
    end
    if (req_valid_i) begin
      if (fail != slave_state_pkg::ERR_NONE) begin
        sm_next.err      = 1'b1;
        sm_next.err_code = fail;
      end else begin
        sm_next.state    = tgt;
        sm_next.ack      = 1'b1;
        sm_next.err      = 1'b0;
        sm_next.err_code = slave_state_pkg::ERR_NONE;
        if (sm_reg.state == slave_state_pkg::ST_PREOP && tgt == slave_state_pkg::ST_SAFEOP) begin
          sm_next.mem    = input_data_i;
          sm_next.mem_wr = 1'b1;
        end
      end
    end
    sm_next.code = slave_state_pkg::state_code(sm_next.state);
    sm_next.mbx  = sm_next.state inside {slave_state_pkg::ST_PREOP, slave_state_pkg::ST_SAFEOP,
                                         slave_state_pkg::ST_OP};
    sm_next.eoe  = sm_next.mbx;
    sm_next.foe  = sm_next.state == slave_state_pkg::ST_BOOT;
    sm_next.pd   = sm_next.state inside {slave_state_pkg::ST_SAFEOP, slave_state_pkg::ST_OP};
    if (cycle_i && !sm_next.mem_wr && sm_reg.pd) begin
      sm_next.mem    = input_data_i;
      sm_next.mem_wr = 1'b1;
    end
    if (sm_next.state != slave_state_pkg::ST_OP) begin
      sm_next.outs = '0;
    end else if (cycle_i && sm_reg.state == slave_state_pkg::ST_OP) begin
      sm_next.outs = master_out_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      sm_reg          <= '0;
      sm_reg.state    <= slave_state_pkg::ST_INIT;
      sm_reg.code     <= slave_state_pkg::ST_INIT_CODE;
      sm_reg.err_code <= slave_state_pkg::ERR_NONE;
    end else begin
      sm_reg <= sm_next;
    end
  end

  assign state_code_o               = sm_reg.code;
  assign ack_o                      = sm_reg.ack;
  assign error_o                    = sm_reg.err;
  assign error_code_o               = sm_reg.err_code;
  assign mailbox_en_o               = sm_reg.mbx;
  assign eoe_en_o                   = sm_reg.eoe;
  assign file_xfer_en_o             = sm_reg.foe;
  assign pd_en_o                    = sm_reg.pd;
  assign mem_wr_o                   = sm_reg.mem_wr;
  assign dual_port_process_memory_o = sm_reg.mem;
  assign phys_out_o                 = sm_reg.outs;

  sequence seq_req_to_preop;
    req_valid_i && req_state_i == slave_state_pkg::ST_PREOP_CODE;
  endsequence

  sequence seq_in_init;
    state_code_o == slave_state_pkg::ST_INIT_CODE;
  endsequence

  AST_INIT_NO_SERVICES: assert property (@(posedge clk_i) disable iff (!rstn)
    seq_in_init |-> !mailbox_en_o && !pd_en_o) else $error("Init allows services");
  AST_PREOP_GATING: assert property (@(posedge clk_i) disable iff (!rstn)
    state_code_o == slave_state_pkg::ST_PREOP_CODE |-> mailbox_en_o && eoe_en_o && !pd_en_o)
    else $error("Pre-Op gating wrong");
  AST_MBX_CHECK: assert property (@(posedge clk_i) disable iff (!rstn)
    seq_in_init ##0 seq_req_to_preop ##0 !mailbox_cfg_ok_i |=> seq_in_init and error_o)
    else $error("Bad mailbox config accepted");
  AST_PD_CHECK: assert property (@(posedge clk_i) disable iff (!rstn)
    state_code_o == slave_state_pkg::ST_PREOP_CODE && req_valid_i
    && req_state_i == slave_state_pkg::ST_SAFEOP_CODE && !pd_cfg_ok_i
    |=> state_code_o == slave_state_pkg::ST_PREOP_CODE && error_o
    && error_code_o == slave_state_pkg::ERR_PD_CFG) else $error("Bad process config accepted");
  AST_SAFEOP_COPY: assert property (@(posedge clk_i) disable iff (!rstn)
    $rose(state_code_o == slave_state_pkg::ST_SAFEOP_CODE) && $past(state_code_o) == slave_state_pkg::ST_PREOP_CODE
    |-> mem_wr_o && ack_o && dual_port_process_memory_o == $past(input_data_i)) else $error("Inputs not copied");
  AST_SAFEOP_OUTS_OFF: assert property (@(posedge clk_i) disable iff (!rstn)
    state_code_o == slave_state_pkg::ST_SAFEOP_CODE |-> phys_out_o == '0 && pd_en_o && mailbox_en_o)
    else $error("Safe-Op outputs active");
  AST_OP_OUTPUTS: assert property (@(posedge clk_i) disable iff (!rstn)
    state_code_o == slave_state_pkg::ST_OP_CODE && cycle_i && !req_valid_i
    |=> phys_out_o == $past(master_out_data_i) && mem_wr_o) else $error("Op data not exchanged");
  AST_BOOT_FROM_INIT: assert property (@(posedge clk_i) disable iff (!rstn)
    $rose(file_xfer_en_o) |-> $past(state_code_o) == slave_state_pkg::ST_INIT_CODE && !mailbox_en_o && !pd_en_o)
    else $error("Bootstrap entered wrongly");
  AST_NO_SPONTANEOUS: assert property (@(posedge clk_i) disable iff (!rstn)
    !req_valid_i |=> $stable(state_code_o)) else $error("State changed without request");
  AST_FAIL_HOLDS: assert property (@(posedge clk_i) disable iff (!rstn)
    req_valid_i && req_state_i == slave_state_pkg::ST_OP_CODE && state_code_o == slave_state_pkg::ST_INIT_CODE
    |=> seq_in_init and (error_o && error_code_o == slave_state_pkg::ERR_BAD_TRANSITION))
    else $error("Illegal move not refused");

endmodule
`default_nettype wire

// ---- verification/master_model.sv ----
// Purpose: Behavioural bus master that issues state requests and data cycles.
// Assumes: Bench commands are one-cycle pulses launched on clk_i.
// Notes:   Idle request and data lines show the inverse of their last value.
`timescale 1ns/10ps
`default_nettype none
module master_model #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         go_i,
  input  wire logic [3:0]   code_i,
  input  wire logic         mbx_ok_i,
  input  wire logic         pd_ok_i,
  input  wire logic         cyc_i,
  input  wire logic [W-1:0] data_i,
  output logic              req_valid_o,
  output logic [3:0]        req_state_o,
  output logic              mailbox_cfg_ok_o,
  output logic              pd_cfg_ok_o,
  output logic              cycle_o,
  output logic [W-1:0]      out_data_o
);
  initial begin
    req_valid_o = 1'b0;
    req_state_o = 4'h0;
    mailbox_cfg_ok_o = 1'b0;
    pd_cfg_ok_o = 1'b0;
    cycle_o = 1'b0;
    out_data_o = '0;
  end
  always @(posedge clk_i) begin
    req_valid_o <= go_i;
    req_state_o <= go_i ? code_i : ~req_state_o;
    mailbox_cfg_ok_o <= mbx_ok_i;
    pd_cfg_ok_o <= pd_ok_i;
    cycle_o <= cyc_i;
    out_data_o <= cyc_i ? data_i : ~out_data_o;
  end
endmodule
`default_nettype wire

// ---- verification/tb_fieldbus_slave_state_machine.sv ----
// Purpose: Self-checking bench for the slave state machine.
// Assumes: A behavioural master drives requests and cycles.
// Notes:   Directed corner moves first, then random requests.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_fieldbus_slave_state_machine;
  logic clk, rstn, go, mok, pok, cyc, rv, mc, pc, cy;
  logic [3:0] code, rs, state_code_o, error_code_o;
  logic [15:0] din, mdata, mo, dual_port_process_memory_o, phys_out_o;
  logic ack_o, error_o, mailbox_en_o, eoe_en_o, file_xfer_en_o, pd_en_o, mem_wr_o;
  int seed, fail_count, n_tests, cycles;
  // Each entry is {requested code, mailbox ok, process ok}.
  localparam logic [5:0] DIR [16] = '{6'h09, 6'h13, 6'h0A, 6'h12, 6'h13, 6'h23, 6'h0F, 6'h17,
                                      6'h10, 6'h20, 6'h08, 6'h04, 6'h0C, 6'h0B, 6'h20, 6'h04};
  localparam logic [3:0] CODES [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hF};
  master_model #(.W(16)) master (.clk_i(clk), .go_i(go), .code_i(code), .mbx_ok_i(mok),
    .pd_ok_i(pok), .cyc_i(cyc), .data_i(mdata), .req_valid_o(rv), .req_state_o(rs),
    .mailbox_cfg_ok_o(mc), .pd_cfg_ok_o(pc), .cycle_o(cy), .out_data_o(mo));
  slave_state_machine #(.DATA_W(16)) dut (.clk_i(clk), .rstn_i(rstn), .req_valid_i(rv),
    .req_state_i(rs), .mailbox_cfg_ok_i(mc), .pd_cfg_ok_i(pc), .cycle_i(cy), .input_data_i(din),
    .master_out_data_i(mo), .state_code_o(state_code_o), .ack_o(ack_o), .error_o(error_o),
    .error_code_o(error_code_o), .mailbox_en_o(mailbox_en_o), .eoe_en_o(eoe_en_o),
    .file_xfer_en_o(file_xfer_en_o), .pd_en_o(pd_en_o), .mem_wr_o(mem_wr_o),
    .dual_port_process_memory_o(dual_port_process_memory_o), .phys_out_o(phys_out_o));
  always #12.5 clk = ~clk;
  function automatic logic [3:0] exp_err(input logic [3:0] s, input logic [3:0] r,
                                         input logic m, input logic p);
    logic ok;
    if (!(r inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8})) return slave_state_pkg::ERR_UNKNOWN_STATE;
    ok = (r == 4'h1) || (r == s) || (s == 4'h1 && r inside {4'h2, 4'h3}) ||
         (s == 4'h2 && r == 4'h4) || (s >= 4'h4 && r inside {4'h2, 4'h4, 4'h8});
    if (!ok) return slave_state_pkg::ERR_BAD_TRANSITION;
    if (s == 4'h1 && r == 4'h2 && !m) return slave_state_pkg::ERR_MAILBOX_CFG;
    if (s == 4'h2 && r == 4'h4 && !p) return slave_state_pkg::ERR_PD_CFG;
    return slave_state_pkg::ERR_NONE;
  endfunction
  function automatic logic [3:0] exp_en(input logic [3:0] s);
    case (s)
      4'h2: return 4'hC;
      4'h3: return 4'h2;
      4'h4, 4'h8: return 4'hD;
      default: return 4'h0;
    endcase
  endfunction
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Launches a request or a data cycle and waits until the slave has answered.
  task automatic pulse(input logic is_req);
    go <= is_req;
    cyc <= !is_req;
    @(posedge clk);
    go <= 1'b0;
    cyc <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic req(input logic [3:0] c, input logic m, input logic p);
    logic [3:0] cur, e, nx;
    cur = state_code_o;
    e = exp_err(cur, c, m, p);
    nx = (e == 4'h0) ? c : cur;
    @(posedge clk);
    code <= c;
    mok <= m;
    pok <= p;
    din <= 16'($random(seed));
    pulse(1'b1);
    `CHK(state_code_o, nx)
    `CHK(ack_o, e == 4'h0)
    `CHK(error_o, e != 4'h0)
    `CHK(error_code_o, e)
    `CHK({mailbox_en_o, eoe_en_o, file_xfer_en_o, pd_en_o}, exp_en(nx))
    if (e == 4'h0 && cur == 4'h2 && c == 4'h4) begin
      `CHK(mem_wr_o, 1'b1)
      `CHK(dual_port_process_memory_o, din)
    end
  endtask
  task automatic pd(input logic [3:0] s);
    logic [15:0] d, o;
    d = 16'($random(seed));
    o = 16'($random(seed));
    @(posedge clk);
    din <= d;
    mdata <= o;
    pulse(1'b0);
    `CHK(mem_wr_o, s >= 4'h4)
    if (s >= 4'h4) `CHK(dual_port_process_memory_o, d)
    `CHK(phys_out_o, (s == 4'h8) ? o : 16'h0000)
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    seed = 59525;
    clk = 1'b0;
    rstn = 1'b0;
    {go, mok, pok, cyc, code, din, mdata} = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK(state_code_o, slave_state_pkg::ST_INIT_CODE)
    `CHK({mailbox_en_o, eoe_en_o, file_xfer_en_o, pd_en_o, ack_o, error_o}, 6'h00)
    $display("test reset done");
    foreach (DIR[i]) begin
      req(DIR[i][5:2], DIR[i][1], DIR[i][0]);
      pd(state_code_o);
    end
    $display("test directed done");
    repeat (60) begin
      req(CODES[$unsigned($random(seed)) % 6], ($random(seed) & 3) != 0, ($random(seed) & 3) != 0);
      pd(state_code_o);
    end
    $display("test random done");
    complete_run();
  end
endmodule
`default_nettype wire
